// File: pds_pkg.sv
package pds_pkg;

    localparam int ADDR_W = 10;
    localparam int CNT_W  = 16;

    ////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_OSC_CTRL  = 8'h06;
    localparam logic [7:0] IDX_OSC_FIRST = 8'h07;
    localparam logic [7:0] IDX_OSC_LAST  = 8'h0a;
    localparam logic [7:0] IDX_MEM_SIZE  = 8'h0c;
    localparam logic [7:0] IDX_STATUS    = 8'h10;
    localparam logic [7:0] IDX_PC        = 8'h11;
    localparam logic [7:0] IDX_SP        = 8'h12;
    localparam logic [7:0] IDX_THREAD    = 8'h13;
    localparam logic [7:0] IDX_REGNUM    = 8'h14;
    localparam logic [7:0] IDX_CAUSE     = 8'h15;
    localparam logic [7:0] IDX_TRIG      = 8'h16;
    localparam logic [7:0] IDX_HALT      = 8'h18;
    localparam logic [7:0] IDX_SCR_FIRST = 8'h20;
    localparam logic [7:0] IDX_SCR_LAST  = 8'h27;

    ////////////////////////////////////////////////////////////////////
    // field layout
    localparam logic [31:0] STATUS_DRW_MASK = 32'h0000_06df;
    localparam int          STATUS_ISSUE    = 8;
    localparam int          OSC_EN_CORE     = 1;
    localparam int          OSC_EN_PERIPH   = 0;
    localparam int          CAUSE_BP_LSB    = 16;
    localparam int          CAUSE_TH_LSB    = 8;
    localparam logic [1:0]  OSC_CTRL_RST    = 2'h0;
    localparam logic [2:0]  CAUSE_RST       = 3'h0;

    typedef enum logic [2:0] {
        PDS_CAUSE_NONE   = 3'b000,
        PDS_CAUSE_HOST   = 3'b001,
        PDS_CAUSE_CALL   = 3'b010,
        PDS_CAUSE_IBREAK = 3'b011,
        PDS_CAUSE_DWATCH = 3'b100,
        PDS_CAUSE_RWATCH = 3'b101
    } pds_cause_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } pds_bus_req_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [2:0]  idx;
        logic [31:0] wdata;
    } pds_cfg_req_t;

    typedef struct packed {
        logic        valid;
        logic [10:0] status;
        logic [31:0] pc;
        logic [31:0] sp;
        pds_cause_t  cause;
        logic [7:0]  thread;
        logic [3:0]  bp_hits;
        logic [31:0] data;
    } pds_capture_t;

endpackage : pds_pkg

// File: pds_osc_counter.sv
module pds_osc_counter #(
    parameter int W = 16
) (
    input  wire logic         i_clk,
    input  wire logic         i_por,
    input  wire logic         i_osc_clk,
    input  wire logic         i_enable,
    output logic [W-1:0]      o_count
);

    logic         en_s1_reg;
    logic         en_s2_reg;
    logic [W-1:0] bin_reg;
    logic [W-1:0] gray_reg;
    logic [W-1:0] bin_next;
    logic [W-1:0] g_s1_reg;
    logic [W-1:0] g_s2_reg;
    logic [W-1:0] count_reg;

    function automatic logic [W-1:0] gray2bin(input logic [W-1:0] g);
        logic [W-1:0] b;
        b[W-1] = g[W-1];
        for (int k = W - 2; k >= 0; k--)
        begin
            b[k] = b[k+1] ^ g[k];
        end
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // oscillator domain; only power-on clears it, never system reset
    assign bin_next = bin_reg + W'(1);

    always_ff @(posedge i_osc_clk or posedge i_por)
    begin
        if (i_por)
        begin
            en_s1_reg <= 1'b0;
            en_s2_reg <= 1'b0;
            bin_reg   <= '0;
            gray_reg  <= '0;
        end
        else
        begin
            en_s1_reg <= i_enable;
            en_s2_reg <= en_s1_reg;
            if (en_s2_reg)
            begin
                bin_reg  <= bin_next;
                gray_reg <= bin_next ^ (bin_next >> 1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // tile domain; one bit moves per step so a torn sample is harmless
    always_ff @(posedge i_clk or posedge i_por)
    begin
        if (i_por)
        begin
            g_s1_reg  <= '0;
            g_s2_reg  <= '0;
            count_reg <= '0;
        end
        else
        begin
            g_s1_reg  <= gray_reg;
            g_s2_reg  <= g_s1_reg;
            count_reg <= gray2bin(g_s2_reg);
        end
    end

    assign o_count = count_reg;

endmodule // pds_osc_counter

// File: pds_status_regs.sv
// Our own choice: strobed register access.
module pds_status_regs #(
    parameter logic [31:0] MEM_BYTES = 32'h0008_0000
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_reset,
    input  wire logic                  i_por,
    input  wire logic [3:0]            i_osc_clk,
    input  wire pds_pkg::pds_bus_req_t i_bus,
    output logic [31:0]                o_rdata,
    input  wire pds_pkg::pds_cfg_req_t i_cfg,
    output logic [31:0]                o_cfg_rdata,
    input  wire logic                  i_debug_mode,
    input  wire pds_pkg::pds_capture_t i_capture,
    output logic [1:0]                 o_osc_run,
    output logic [7:0]                 o_remote_thread,
    output logic [4:0]                 o_remote_reg,
    output logic [7:0]                 o_thread_halt
);

    typedef struct packed {
        logic [1:0]       osc_ctrl;
        logic [10:0]      status;
        logic [31:0]      pc;
        logic [31:0]      sp;
        logic [7:0]       thread_sel;
        logic [4:0]       reg_sel;
        logic [2:0]       cause;
        logic [7:0]       cause_thread;
        logic [1:0]       bp_num;
        logic [31:0]      trig_data;
        logic [7:0]       halt_mask;
        logic [7:0][31:0] scratch;
        logic [31:0]      rdata;
        logic [31:0]      cfg_rdata;
        logic [7:0]       halt_out;
    } pds_state_t;

    pds_state_t                           s_reg;
    pds_state_t                           s_next;
    logic [3:0][pds_pkg::CNT_W-1:0]       osc_count;
    logic [7:0]                           idx;
    logic                                 aligned;
    logic                                 drw_ok;

    ////////////////////////////////////////////////////////////////////
    function automatic logic in_range(input logic [7:0] i,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
        return (i >= lo) && (i <= hi);
    endfunction

    function automatic logic [1:0] lowest_hit(input logic [3:0] hits);
        logic [1:0] n;
        n = 2'h0;
        for (int k = 3; k >= 0; k--)
        begin
            if (hits[k])
            begin
                n = 2'(k);
            end
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // core pair on one enable bit, peripheral pair on the other
    for (genvar g = 0; g < 4; g++)
    begin : g_osc
        pds_osc_counter #(
            .W (pds_pkg::CNT_W)
        ) u_osc (
            .i_clk     (i_clk),
            .i_por     (i_por),
            .i_osc_clk (i_osc_clk[g]),
            .i_enable  (g < 2 ? s_reg.osc_ctrl[pds_pkg::OSC_EN_CORE]
                              : s_reg.osc_ctrl[pds_pkg::OSC_EN_PERIPH]),
            .o_count   (osc_count[g])
        );
    end

    assign idx     = i_bus.addr[pds_pkg::ADDR_W-1:2];
    assign aligned = (i_bus.addr[1:0] == 2'h0);
    assign drw_ok  = i_debug_mode;

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_next          = s_reg;
        s_next.rdata    = 32'h0000_0000;
        s_next.halt_out = s_reg.halt_mask & ~{8{i_debug_mode}};

        // configuration path first so the processor path wins a tie
        if (i_cfg.wr)
        begin
            s_next.scratch[i_cfg.idx] = i_cfg.wdata;
        end
        if (i_cfg.rd)
        begin
            s_next.cfg_rdata = s_reg.scratch[i_cfg.idx];
        end
        else
        begin
            s_next.cfg_rdata = 32'h0000_0000;
        end

        if (i_bus.wr && aligned)
        begin
            if (idx == pds_pkg::IDX_OSC_CTRL)
            begin
                s_next.osc_ctrl = i_bus.wdata[1:0];
            end
            else if (drw_ok && idx == pds_pkg::IDX_STATUS)
            begin
                // issue-mode bit stays as captured
                s_next.status = 11'((i_bus.wdata & pds_pkg::STATUS_DRW_MASK)
                    | ({21'h0, s_reg.status}
                       & ~pds_pkg::STATUS_DRW_MASK));
            end
            else if (drw_ok && idx == pds_pkg::IDX_PC)
            begin
                s_next.pc = i_bus.wdata;
            end
            else if (drw_ok && idx == pds_pkg::IDX_SP)
            begin
                s_next.sp = i_bus.wdata;
            end
            else if (drw_ok && idx == pds_pkg::IDX_THREAD)
            begin
                s_next.thread_sel = i_bus.wdata[7:0];
            end
            else if (drw_ok && idx == pds_pkg::IDX_REGNUM)
            begin
                s_next.reg_sel = i_bus.wdata[4:0];
            end
            else if (drw_ok && idx == pds_pkg::IDX_CAUSE)
            begin
                s_next.cause        = i_bus.wdata[2:0];
                s_next.cause_thread = i_bus.wdata[15:8];
                s_next.bp_num       = i_bus.wdata[17:16];
            end
            else if (drw_ok && idx == pds_pkg::IDX_TRIG)
            begin
                s_next.trig_data = i_bus.wdata;
            end
            else if (drw_ok && idx == pds_pkg::IDX_HALT)
            begin
                s_next.halt_mask = i_bus.wdata[7:0];
            end
            else if (drw_ok && in_range(idx, pds_pkg::IDX_SCR_FIRST,
                                        pds_pkg::IDX_SCR_LAST))
            begin
                s_next.scratch[idx[2:0]] = i_bus.wdata;
            end
        end

        // hardware capture overrides a software write in the same cycle
        if (i_capture.valid)
        begin
            s_next.status    = i_capture.status
                & (11'(pds_pkg::STATUS_DRW_MASK)
                   | (11'h001 << pds_pkg::STATUS_ISSUE));
            s_next.pc        = i_capture.pc;
            s_next.sp        = i_capture.sp;
            s_next.cause     = i_capture.cause;
            s_next.trig_data = i_capture.data;
            if (i_capture.cause == pds_pkg::PDS_CAUSE_HOST)
            begin
                s_next.cause_thread = 8'h00;
            end
            else
            begin
                s_next.cause_thread = i_capture.thread;
            end
            if (i_capture.cause == pds_pkg::PDS_CAUSE_HOST
                || i_capture.cause == pds_pkg::PDS_CAUSE_CALL)
            begin
                s_next.bp_num = 2'h0;
            end
            else
            begin
                s_next.bp_num = lowest_hit(i_capture.bp_hits);
            end
        end

        if (i_bus.rd && aligned)
        begin
            if (idx == pds_pkg::IDX_OSC_CTRL)
            begin
                s_next.rdata = {30'h0, s_reg.osc_ctrl};
            end
            else if (in_range(idx, pds_pkg::IDX_OSC_FIRST,
                              pds_pkg::IDX_OSC_LAST))
            begin
                s_next.rdata = {16'h0000,
                    osc_count[2'(idx - pds_pkg::IDX_OSC_FIRST)]};
            end
            else if (idx == pds_pkg::IDX_MEM_SIZE)
            begin
                s_next.rdata = {MEM_BYTES[31:2], 2'b00};
            end
            else if (idx == pds_pkg::IDX_STATUS)
            begin
                s_next.rdata = {21'h0, s_reg.status};
            end
            else if (idx == pds_pkg::IDX_PC)
            begin
                s_next.rdata = s_reg.pc;
            end
            else if (idx == pds_pkg::IDX_SP)
            begin
                s_next.rdata = s_reg.sp;
            end
            else if (idx == pds_pkg::IDX_THREAD)
            begin
                s_next.rdata = {24'h0, s_reg.thread_sel};
            end
            else if (idx == pds_pkg::IDX_REGNUM)
            begin
                s_next.rdata = {27'h0, s_reg.reg_sel};
            end
            else if (idx == pds_pkg::IDX_CAUSE)
            begin
                s_next.rdata = {14'h0, s_reg.bp_num, s_reg.cause_thread,
                                5'h00, s_reg.cause};
            end
            else if (idx == pds_pkg::IDX_TRIG)
            begin
                s_next.rdata = s_reg.trig_data;
            end
            else if (idx == pds_pkg::IDX_HALT)
            begin
                s_next.rdata = {24'h0, s_reg.halt_mask};
            end
            else if (in_range(idx, pds_pkg::IDX_SCR_FIRST,
                              pds_pkg::IDX_SCR_LAST))
            begin
                s_next.rdata = s_reg.scratch[idx[2:0]];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // every documented reset value is zero
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign o_rdata         = s_reg.rdata;
    assign o_cfg_rdata     = s_reg.cfg_rdata;
    assign o_osc_run       = s_reg.osc_ctrl;
    assign o_remote_thread = s_reg.thread_sel;
    assign o_remote_reg    = s_reg.reg_sel;
    assign o_thread_halt   = s_reg.halt_out;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    sequence s_rd(logic [7:0] k);
        i_bus.rd && aligned && idx == k;
    endsequence

    sequence s_wr_dbg(logic [7:0] k);
        i_bus.wr && aligned && idx == k && i_debug_mode && !i_capture.valid;
    endsequence

    property p_osc_upper;
        s_rd(pds_pkg::IDX_OSC_FIRST) |=> o_rdata[31:16] == 16'h0000;
    endproperty
    a_osc_upper: assert property (p_osc_upper)
        else $error("oscillator count upper half not zero");

    property p_mem_size;
        s_rd(pds_pkg::IDX_MEM_SIZE) |=> o_rdata == {MEM_BYTES[31:2], 2'b00};
    endproperty
    a_mem_size: assert property (p_mem_size)
        else $error("memory size read wrong");

    property p_cap_status;
        i_capture.valid ##1 !i_bus.wr && !i_capture.valid
            ##1 s_rd(pds_pkg::IDX_STATUS)
            |=> o_rdata[10:0] == ($past(i_capture.status, 3) & 11'h7df);
    endproperty
    a_cap_status: assert property (p_cap_status)
        else $error("captured status not read back");

    property p_cap_pc;
        i_capture.valid |=> s_reg.pc == $past(i_capture.pc);
    endproperty
    a_cap_pc: assert property (p_cap_pc)
        else $error("program counter not captured");

    property p_cap_sp;
        i_capture.valid |=> s_reg.sp == $past(i_capture.sp);
    endproperty
    a_cap_sp: assert property (p_cap_sp)
        else $error("stack pointer not captured");

    property p_host_zero;
        i_capture.valid && i_capture.cause == pds_pkg::PDS_CAUSE_HOST
            |=> s_reg.cause_thread == 8'h00 && s_reg.bp_num == 2'h0;
    endproperty
    a_host_zero: assert property (p_host_zero)
        else $error("host entry left thread or number nonzero");

    property p_bp_lowest;
        i_capture.valid && i_capture.bp_hits != 4'h0
            && i_capture.cause >= pds_pkg::PDS_CAUSE_IBREAK
            |=> (($past(i_capture.bp_hits) >> s_reg.bp_num) & 4'h1) != 4'h0
            && ($past(i_capture.bp_hits) & ~(4'hf << s_reg.bp_num)) == 4'h0;
    endproperty
    a_bp_lowest: assert property (p_bp_lowest)
        else $error("breakpoint number not lowest");

    property p_drw_ignored;
        i_bus.wr && aligned && idx == pds_pkg::IDX_PC && !i_debug_mode
            && !i_capture.valid |=> $stable(s_reg.pc);
    endproperty
    a_drw_ignored: assert property (p_drw_ignored)
        else $error("write outside debug mode took effect");

    property p_issue_ro;
        s_wr_dbg(pds_pkg::IDX_STATUS) |=> $stable(s_reg.status[8]);
    endproperty
    a_issue_ro: assert property (p_issue_ro)
        else $error("issue mode bit written");

    property p_remote;
        s_wr_dbg(pds_pkg::IDX_THREAD)
            |=> o_remote_thread == $past(i_bus.wdata[7:0]);
    endproperty
    a_remote: assert property (p_remote)
        else $error("remote thread operand wrong");

    property p_halt;
        !i_debug_mode ##1 !i_debug_mode
            |=> o_thread_halt == $past(s_reg.halt_mask);
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt mask not applied outside debug");

    sequence s_cfg_then_rd;
        i_cfg.wr && i_cfg.idx == 3'h2 && !i_bus.wr
            ##1 !i_bus.wr && !i_cfg.wr ##1 s_rd(8'h22);
    endsequence
    property p_scratch_shared;
        s_cfg_then_rd |=> o_rdata == $past(i_cfg.wdata, 3);
    endproperty
    a_scratch_shared: assert property (p_scratch_shared)
        else $error("scratch word not shared");

    property p_cause_rst;
        @(posedge i_clk) disable iff (1'b0)
            i_reset |=> s_reg.cause == pds_pkg::CAUSE_RST;
    endproperty
    a_cause_rst: assert property (p_cause_rst)
        else $error("cause not cleared by reset");

endmodule // pds_status_regs

// File: pds_osc_partner.sv
module pds_osc_partner (
    input  wire logic [1:0] i_run,
    output logic      [3:0] o_osc_clk
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////
    // rings free-run while enabled; a short tail after disable
    // lets the counter's own synchroniser see the enable fall
    initial o_osc_clk = 4'h0;
    for (genvar g = 0; g < 4; g++)
    begin : g_ring
        int tail = 0;
        always
        begin
            #(3.1 + 0.7 * g);
            if (i_run[g < 2 ? 1 : 0])
                tail = 8;
            if (tail > 0)
            begin
                o_osc_clk[g] = ~o_osc_clk[g];
                tail = tail - 1;
            end
        end
    end
endmodule // pds_osc_partner

// File: pds_status_regs_tb_top.sv
module pds_status_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] MEM = 32'h0001_2347;

    logic                  i_clk = 1'b0;
    logic                  i_reset = 1'b1;
    logic                  i_por = 1'b1;
    logic                  dbg = 1'b0;
    logic [3:0]            osc;
    pds_pkg::pds_bus_req_t bus = '0;
    pds_pkg::pds_cfg_req_t cfg = '0;
    pds_pkg::pds_capture_t cap = '0;
    logic [31:0]           rdata;
    logic [31:0]           cfg_rdata;
    logic [31:0]           got;
    logic [31:0]           mdl [0:63];
    logic [15:0]           cnt [0:3];
    logic [1:0]            osc_run;
    logic [7:0]            r_thread;
    logic [7:0]            halt;
    logic [4:0]            r_reg;
    int                    errors = 0;
    int                    check_count = 0;

    always #10 i_clk = ~i_clk;

    pds_status_regs #(.MEM_BYTES(MEM)) u_pds_status_regs (
        .i_clk(i_clk), .i_reset(i_reset), .i_por(i_por),
        .i_osc_clk(osc), .i_bus(bus), .o_rdata(rdata), .i_cfg(cfg),
        .o_cfg_rdata(cfg_rdata), .i_debug_mode(dbg), .i_capture(cap),
        .o_osc_run(osc_run), .o_remote_thread(r_thread),
        .o_remote_reg(r_reg), .o_thread_halt(halt));

    pds_osc_partner u_pds_osc_partner (.i_run(osc_run), .o_osc_clk(osc));

    ////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check_reg(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %0t reg got %h exp %h", $time, g, e);
        end
    endtask

    task automatic check_port(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %0t port got %h exp %h", $time, g, e);
        end
    endtask

    // writable bits of each index; reserved bits read zero
    function automatic logic [31:0] wmask(input logic [7:0] idx);
        case (idx)
            8'h06: return 32'h0000_0003;
            8'h10: return 32'h0000_06df;
            8'h11, 8'h12, 8'h16: return 32'hffff_ffff;
            8'h13, 8'h18: return 32'h0000_00ff;
            8'h14: return 32'h0000_001f;
            8'h15: return 32'h0003_ff07;
            default: return (idx >= 8'h20 && idx <= 8'h27) ?
                            32'hffff_ffff : 32'h0000_0000;
        endcase
    endfunction

    task automatic bus_op(input logic w, input logic [9:0] a,
                          input logic [31:0] d);
        @(posedge i_clk);
        bus <= '{wr: w, rd: ~w, addr: a, wdata: d};
        @(posedge i_clk);
        bus <= '0;
        #1 got = rdata;
        if (w && (a[9:2] == 8'h06 || dbg))
            mdl[a[9:2]] = d & wmask(a[9:2]);
    endtask

    task automatic rd_chk(input logic [7:0] idx);
        bus_op(1'b0, {idx, 2'b00}, 32'h0000_0000);
        check_reg(got, mdl[idx]);
    endtask

    task automatic cfg_op(input logic w, input int k, input logic [31:0] d);
        @(posedge i_clk);
        cfg <= '{wr: w, rd: ~w, idx: 3'(k), wdata: d};
        @(posedge i_clk);
        cfg <= '0;
        #1 got = cfg_rdata;
        if (w)
            mdl[32 + k] = d;
    endtask

    task automatic capture(input pds_pkg::pds_cause_t c);
        pds_pkg::pds_capture_t v;
        logic [1:0] bp;
        logic [127:0] raw;
        raw = {$urandom, $urandom, $urandom, $urandom};
        v = raw[$bits(pds_pkg::pds_capture_t)-1:0];
        v.valid = 1'b1;
        v.cause = c;
        v.bp_hits = 4'($urandom_range(1, 15));
        @(posedge i_clk);
        cap <= v;
        @(posedge i_clk);
        cap <= '0;
        bp = 2'h0;
        for (int i = 3; i >= 0; i--)
            if (v.bp_hits[i] && c >= pds_pkg::PDS_CAUSE_IBREAK)
                bp = 2'(i);
        if (c == pds_pkg::PDS_CAUSE_HOST)
            v.thread = 8'h00;
        mdl[8'h10] = {21'h0, v.status & 11'h7df};
        mdl[8'h11] = v.pc;
        mdl[8'h12] = v.sp;
        mdl[8'h16] = v.data;
        mdl[8'h15] = {14'h0, bp, v.thread, 5'h00, c};
    endtask

    task automatic read_counts(input logic [3:0] same);
        for (int i = 0; i < 4; i++)
        begin
            bus_op(1'b0, {8'(7 + i), 2'b00}, 32'h0000_0000);
            check_reg({16'h0000, got[31:16]}, 32'h0000_0000);
            check_reg({31'h0, (got[15:0] == cnt[i]) == same[i]}, 32'h1);
            cnt[i] = got[15:0];
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // the counts are never predicted exactly: the ring rate is
    // unrelated to the tile clock, so only changes are judged
    initial
    begin
        void'($urandom(32'h3c00ad9f));
        for (int i = 0; i < 64; i++)
            mdl[i] = 32'h0000_0000;
        mdl[8'h0c] = MEM & 32'hffff_fffc;
        for (int i = 0; i < 4; i++)
            cnt[i] = 16'h0000;
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        i_por <= 1'b0;
        for (int i = 7; i < 40; i++)
            bus_op(1'b1, {8'(i), 2'b00}, $urandom);
        for (int i = 12; i < 49; i++)
            rd_chk(8'(i));
        bus_op(1'b0, 10'h041, 32'h0000_0000);
        check_reg(got, 32'h0000_0000);
        $display("test gating done");
        dbg <= 1'b1;
        for (int i = 16; i < 40; i++)
            bus_op(1'b1, {8'(i), 2'b00}, $urandom);
        for (int i = 16; i < 40; i++)
            rd_chk(8'(i));
        check_port(r_thread, mdl[8'h13][7:0]);
        check_port({3'h0, r_reg}, {3'h0, mdl[8'h14][4:0]});
        check_port(halt, 8'h00);
        dbg <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1 check_port(halt, mdl[8'h18][7:0]);
        $display("test debug fields done");
        for (int c = 1; c <= 5; c++)
        begin
            capture(pds_pkg::pds_cause_t'(c));
            rd_chk(8'h10);
            rd_chk(8'h11);
            rd_chk(8'h12);
            rd_chk(8'h15);
            rd_chk(8'h16);
        end
        $display("test capture done");
        for (int k = 0; k < 8; k++)
        begin
            dbg <= 1'b1;
            bus_op(1'b1, {8'(32 + k), 2'b00}, $urandom);
            cfg_op(1'b0, k, 32'h0000_0000);
            check_reg(got, mdl[32 + k]);
            dbg <= 1'b0;
            cfg_op(1'b1, k, $urandom);
            rd_chk(8'(32 + k));
        end
        $display("test scratch done");
        bus_op(1'b1, 10'h018, 32'hffff_ffff);
        check_port({6'h0, osc_run}, 8'h03);
        repeat (200) @(posedge i_clk);
        bus_op(1'b1, 10'h018, 32'h0000_0000);
        repeat (12) @(posedge i_clk);
        read_counts(4'h0);
        @(posedge i_clk);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        for (int i = 16; i < 40; i++)
            mdl[i] = 32'h0000_0000;
        #1 check_port({6'h0, osc_run}, 8'h00);
        read_counts(4'hf);
        rd_chk(8'h15);
        bus_op(1'b1, 10'h018, 32'h0000_0001);
        repeat (100) @(posedge i_clk);
        bus_op(1'b1, 10'h018, 32'h0000_0000);
        repeat (12) @(posedge i_clk);
        read_counts(4'h3);
        $display("test oscillators done");
        tally_and_finish();
    end

    // hang guard well beyond the longest sequence
    initial
    begin
        #1000000;
        errors++;
        $display("[FAIL] %0t run did not finish", $time);
        tally_and_finish();
    end
endmodule // pds_status_regs_tb_top
